// *** hdl/gain_control_serial_port.sv ***
`timescale 1ns/1ns
`include "gain_ctrl_defines.svh"

// Overview of operation
// - Serial clock up to 10 MHz works.
// - Transfer begins on chip select falling.
// - Rising serial clock shifts data in.
// - Shift-out bit changes on falling clock.
// - Data output released while deselected.
// - Deselected: clocks ignored, state kept.
// - Word is MSB first, fixed field layout.
// - Gain code steps 3 dB each.
// - Gain code resets to zero.
// - Each aux bit drives its pin.
// - Aux outputs reset to off.
// - Zero-cross selects act independently.
// - Zero-cross selects reset to immediate.
// - Deferred change applies on zero or timeout.
// - Chained devices update on select rising.
module gain_control_serial_port (
    input  wire logic                     clk_i,
    input  wire logic                     rst_n_i,
    input  wire logic                     cs_n_i,
    input  wire logic                     sclk_i,
    input  wire logic                     sdi_i,
    input  wire logic                     zero_cross_i,
    input  wire logic                     zc_timeout_i,
    output logic                          sdo_o,
    output logic                          sdo_oe_o,
    output gain_ctrl_pkg::gain_code_t     gain_code_o,
    output gain_ctrl_pkg::gain_code_t     gain_step_o,
    output gain_ctrl_pkg::aux_bits_t      aux_output_o,
    output logic                          level_zc_mode_o,
    output logic                          aux_output_zc_mode_o,
    output logic                          level_pending_o,
    output logic                          aux_pending_o
);
    import gain_ctrl_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [1:0] cs_s_q;
    logic [1:0] sclk_s_q;
    logic [1:0] sdi_s_q;
    logic [1:0] zc_s_q;
    logic [1:0] to_s_q;
    logic       cs_prev_q;
    logic       sclk_prev_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cs_s_q      <= 2'h3;
            sclk_s_q    <= 2'h0;
            sdi_s_q     <= 2'h0;
            zc_s_q      <= 2'h0;
            to_s_q      <= 2'h0;
            cs_prev_q   <= 1'b1;
            sclk_prev_q <= 1'b0;
        end else begin
            cs_s_q      <= {cs_s_q[0], cs_n_i};
            sclk_s_q    <= {sclk_s_q[0], sclk_i};
            sdi_s_q     <= {sdi_s_q[0], sdi_i};
            zc_s_q      <= {zc_s_q[0], zero_cross_i};
            to_s_q      <= {to_s_q[0], zc_timeout_i};
            cs_prev_q   <= cs_s_q[1];
            sclk_prev_q <= sclk_s_q[1];
        end
    end

    // ------------------------------------------------------------
    // Edge decoding
    // ------------------------------------------------------------
    // Two-stage sync plus edge detect needs ten clocks per serial period.
    wire selected  = ~cs_s_q[1];
    wire cs_fall   = cs_prev_q & ~cs_s_q[1];
    wire cs_rise   = ~cs_prev_q & cs_s_q[1];
    wire sclk_rise = selected & ~sclk_prev_q & sclk_s_q[1];
    wire sclk_fall = selected & sclk_prev_q & ~sclk_s_q[1];
    wire apply_evt = zc_s_q[1] | to_s_q[1];

    // ------------------------------------------------------------
    // Shift register
    // ------------------------------------------------------------
    cfg_word_t shift_q;
    cfg_word_t shift_d;
    logic      sdo_q;
    logic      sdo_d;
    logic      active_q;

    // Select falling also presents the top bit, so a chained device
    // receives it on the first rising edge of the frame.
    wire sdo_load = cs_fall | (active_q & sclk_fall);

    assign shift_d = sclk_rise ? {shift_q[14:0], sdi_s_q[1]} : shift_q;
    assign sdo_d   = sdo_load ? shift_q[`WORD_BITS-1] : sdo_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            active_q <= 1'b0;
        end else if (cs_fall) begin
            active_q <= 1'b1;
        end else if (cs_rise) begin
            active_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shift_q <= 16'h0000;
        end else if (active_q) begin
            shift_q <= shift_d;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sdo_q <= 1'b0;
        end else begin
            sdo_q <= sdo_d;
        end
    end

    assign sdo_o    = sdo_q;
    assign sdo_oe_o = selected;

    // ------------------------------------------------------------
    // Word fields
    // ------------------------------------------------------------
    wire gain_code_t new_gain  = shift_q[`GAIN_MSB_POS:`GAIN_LSB_POS];
    wire aux_bits_t  new_aux   = shift_q[`AUX_MSB_POS:`AUX_LSB_POS];
    wire             new_azc   = shift_q[`AUX_ZC_POS];
    wire             new_lzc   = shift_q[`LEVEL_ZC_POS];
    // Master must raise select after the last clock for a clean word.
    wire             latch_evt = cs_rise & active_q;

    function automatic gain_code_t sat_gain(input gain_code_t c);
        sat_gain = (c > `GAIN_MAX_CODE) ? `GAIN_MAX_CODE : c;
    endfunction

    // ------------------------------------------------------------
    // Configuration and deferred updates
    // ------------------------------------------------------------
    gain_code_t gain_q;
    gain_code_t gain_pend_q;
    aux_bits_t  aux_q;
    aux_bits_t  aux_pend_q;
    logic       lzc_q;
    logic       azc_q;
    logic       lpend_q;
    logic       apend_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lzc_q <= `ZC_RESET;
            azc_q <= `ZC_RESET;
        end else if (latch_evt) begin
            lzc_q <= new_lzc;
            azc_q <= new_azc;
        end
    end

    // A newly latched deferred word replaces any pending one.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gain_q      <= `GAIN_RESET;
            gain_pend_q <= `GAIN_RESET;
            lpend_q     <= 1'b0;
        end else if (latch_evt && !new_lzc) begin
            gain_q  <= new_gain;
            lpend_q <= 1'b0;
        end else if (latch_evt) begin
            gain_pend_q <= new_gain;
            lpend_q     <= 1'b1;
        end else if (lpend_q && apply_evt) begin
            gain_q  <= gain_pend_q;
            lpend_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aux_q      <= `AUX_RESET;
            aux_pend_q <= `AUX_RESET;
            apend_q    <= 1'b0;
        end else if (latch_evt && !new_azc) begin
            aux_q   <= new_aux;
            apend_q <= 1'b0;
        end else if (latch_evt) begin
            aux_pend_q <= new_aux;
            apend_q    <= 1'b1;
        end else if (apend_q && apply_evt) begin
            aux_q   <= aux_pend_q;
            apend_q <= 1'b0;
        end
    end

    assign gain_code_o          = gain_q;
    assign gain_step_o          = sat_gain(gain_q);
    assign aux_output_o         = aux_q;
    assign level_zc_mode_o      = lzc_q;
    assign aux_output_zc_mode_o = azc_q;
    assign level_pending_o      = lpend_q;
    assign aux_pending_o        = apend_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_oe_off;
        @(posedge clk_i) disable iff (!rst_n_i)
        // The pin as it stood two clocks ago is the synchronised select.
        $past(cs_n_i, 2) |-> !sdo_oe_o;
    endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("data output driven while deselected");

    property p_idle_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
        (cs_s_q[1] && !active_q) |=> $stable(shift_q);
    endproperty
    a_idle_hold: assert property (p_idle_hold)
        else $error("shift register moved while deselected");

    property p_shift_in;
        @(posedge clk_i) disable iff (!rst_n_i)
        (sclk_rise && active_q) |=>
            shift_q == {$past(shift_q[14:0]), $past(sdi_s_q[1])};
    endproperty
    a_shift_in: assert property (p_shift_in)
        else $error("rising serial clock did not shift");

    property p_shift_out;
        @(posedge clk_i) disable iff (!rst_n_i)
        (sclk_fall && active_q) |=> sdo_o == $past(shift_q[15]);
    endproperty
    a_shift_out: assert property (p_shift_out)
        else $error("data output not updated on falling clock");

    property p_gain_sat;
        @(posedge clk_i) disable iff (!rst_n_i)
        (gain_code_o > `GAIN_MAX_CODE) ?
            (gain_step_o == `GAIN_MAX_CODE) :
            (gain_step_o == gain_code_o);
    endproperty
    a_gain_sat: assert property (p_gain_sat)
        else $error("gain step not saturated");

    property p_imm_gain;
        @(posedge clk_i) disable iff (!rst_n_i)
        (latch_evt && !new_lzc) |=> gain_q == $past(new_gain);
    endproperty
    a_imm_gain: assert property (p_imm_gain)
        else $error("immediate gain update missed");

    property p_defer_apply;
        @(posedge clk_i) disable iff (!rst_n_i)
        (lpend_q && apply_evt && !latch_evt) |=>
            gain_q == $past(gain_pend_q) && !lpend_q;
    endproperty
    a_defer_apply: assert property (p_defer_apply)
        else $error("deferred gain not applied");

    sequence s_defer_latch;
        latch_evt && new_azc;
    endsequence
    property p_aux_pend;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_defer_latch |=> apend_q && aux_pend_q == $past(new_aux);
    endproperty
    a_aux_pend: assert property (p_aux_pend)
        else $error("deferred aux value not held");

    property p_sdo_load;
        @(posedge clk_i) disable iff (!rst_n_i)
        cs_fall |=> sdo_o == $past(shift_q[15]);
    endproperty
    a_sdo_load: assert property (p_sdo_load)
        else $error("first outgoing bit not presented at select");

    property p_aux_imm;
        @(posedge clk_i) disable iff (!rst_n_i)
        (latch_evt && !new_azc) |=> aux_q == $past(new_aux) && !apend_q;
    endproperty
    a_aux_imm: assert property (p_aux_imm)
        else $error("immediate aux update missed");

    property p_cfg_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
        (!latch_evt && !apply_evt) |=> $stable(gain_q) && $stable(aux_q);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold)
        else $error("settings changed without select rising or apply");

    sequence s_level_defer;
        latch_evt && new_lzc;
    endsequence
    property p_gain_pend;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_level_defer |=> lpend_q && gain_pend_q == $past(new_gain);
    endproperty
    a_gain_pend: assert property (p_gain_pend)
        else $error("deferred gain value not held");

endmodule // gain_control_serial_port

// *** inc/gain_ctrl_defines.svh ***
`ifndef GAIN_CTRL_DEFINES_SVH
`define GAIN_CTRL_DEFINES_SVH

`define WORD_BITS        16
`define GAIN_MSB_POS     12
`define GAIN_LSB_POS     8
`define AUX_ZC_POS       5
`define LEVEL_ZC_POS     4
`define AUX_MSB_POS      3
`define AUX_LSB_POS      0
`define GAIN_RESET       5'h00
`define GAIN_MAX_CODE    5'h14
`define AUX_RESET        4'h0
`define ZC_RESET         1'b0
`define SCLK_MAX_MHZ     10
`define CLK_MHZ          100
`define SCLK_MIN_CYCLES  (`CLK_MHZ / `SCLK_MAX_MHZ)

`endif

// *** inc/gain_ctrl_pkg.sv ***
package gain_ctrl_pkg;
    typedef logic [4:0] gain_code_t;
    typedef logic [3:0] aux_bits_t;
    typedef logic [15:0] cfg_word_t;
endpackage

// *** testbench/spi_host_model.sv ***
`timescale 1ns/1ns
module spi_host_model (
    output logic      cs_n_o,
    output logic      sclk_o,
    output logic      sdi_o,
    input  wire logic sdo_i,
    input  wire logic sdo_oe_i
);
    import gain_ctrl_pkg::*;
    cfg_word_t rx_q;
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        sdi_o  = 1'b0;
        rx_q   = '0;
    end
    // Low 62 ns and high 63 ns give a 125 ns serial clock.
    // Edges sit clear of the system clock's rising edge. The output is
    // read just before each rising edge; a released line reads inverted.
    task automatic put_bit(input logic b);
        #2 sdi_o = b;
        #6 rx_q = {rx_q[14:0], sdo_oe_i ? sdo_i : ~sdo_i};
        sclk_o = 1'b1;
        #63 sclk_o = 1'b0;
        #54;
    endtask
    // A frame opens with select falling and closes with it rising.
    task automatic shift_n(input logic [19:0] w, input int n);
        cs_n_o = 1'b0;
        #55;
        for (int i = n - 1; i >= 0; i--) put_bit(w[i]);
        #3;
        cs_n_o = 1'b1;
        sdi_o  = ~sdi_o;
        #60;
    endtask
    task automatic send16(input cfg_word_t w);
        shift_n({4'h0, w}, 16);
    endtask
    task automatic send20(input logic [19:0] w);
        shift_n(w, 20);
    endtask
    task automatic idle_clocks();
        for (int i = 0; i < 16; i++) begin
            #2 sdi_o = ~sdi_o;
            #6 sclk_o = 1'b1;
            #63 sclk_o = 1'b0;
            #54;
        end
    endtask
endmodule // spi_host_model

// *** testbench/test_gain_control_serial_port.sv ***
`timescale 1ns/1ns
module test_gain_control_serial_port;
    import gain_ctrl_pkg::*;
    logic       clk_i = 1'b0;
    logic       rst_n_i = 1'b0;
    logic       zc_i = 1'b0;
    logic       tmo_i = 1'b0;
    wire logic  cs_n, sclk, sdi, sdo, oe, lzc, azc, lpd, apd;
    gain_code_t code, step;
    aux_bits_t  aux;
    int         err_count = 0;
    int         n_tests = 0;
    always #5 clk_i = ~clk_i;
    spi_host_model u_host (.cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi),
        .sdo_i(sdo), .sdo_oe_i(oe));
    gain_control_serial_port u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .cs_n_i(cs_n), .sclk_i(sclk), .sdi_i(sdi), .zero_cross_i(zc_i),
        .zc_timeout_i(tmo_i), .sdo_o(sdo), .sdo_oe_o(oe),
        .gain_code_o(code), .gain_step_o(step), .aux_output_o(aux),
        .level_zc_mode_o(lzc), .aux_output_zc_mode_o(azc),
        .level_pending_o(lpd), .aux_pending_o(apd));
    task automatic fail(input string m);
        $display("[FAIL] %0t %s", $time, m);
        err_count++;
    endtask
    task automatic chk5(input gain_code_t g, input gain_code_t e);
        n_tests++;
        if (g !== e) fail("gain field");
    endtask
    task automatic chk4(input aux_bits_t g, input aux_bits_t e);
        n_tests++;
        if (g !== e) fail("aux field");
    endtask
    task automatic chk1(input logic g, input logic e, input string m);
        n_tests++;
        if (g !== e) fail(m);
    endtask
    task automatic chkw(input cfg_word_t g, input cfg_word_t e);
        n_tests++;
        if (g !== e) fail("shifted out word");
    endtask
    function automatic cfg_word_t mk(gain_code_t g, logic az, logic lz,
                                     aux_bits_t a);
        return {3'h0, g, 2'h0, az, lz, a};
    endfunction
    task automatic send(input cfg_word_t w);
        u_host.send16(w);
        repeat (10) @(negedge clk_i);
    endtask
    task automatic pulse(input bit tmo);
        if (tmo) tmo_i = 1'b1; else zc_i = 1'b1;
        repeat (2) @(negedge clk_i);
        tmo_i = 1'b0;
        zc_i  = 1'b0;
        repeat (10) @(negedge clk_i);
    endtask
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------
    task automatic t_reset();
        rst_n_i = 1'b0;
        repeat (5) @(negedge clk_i);
        chk5(code, 5'h00);
        chk5(step, 5'h00);
        chk4(aux, 4'h0);
        chk1(lzc | azc, 1'b0, "zc modes");
        chk1(lpd | apd, 1'b0, "pending at reset");
        chk1(oe, 1'b0, "output enable idle");
        rst_n_i = 1'b1;
        repeat (5) @(negedge clk_i);
    endtask
    task automatic t_codes();
        gain_code_t tbl[5] = '{5'h0D, 5'h13, 5'h14, 5'h15, 5'h1F};
        foreach (tbl[i]) begin
            send(mk(tbl[i], 1'b0, 1'b0, 4'hA ^ 4'(i)));
            chk5(code, tbl[i]);
            chk5(step, tbl[i] > 5'h14 ? 5'h14 : tbl[i]);
            chk4(aux, 4'hA ^ 4'(i));
        end
    endtask
    task automatic t_idle_and_chain();
        cfg_word_t w = mk(5'h02, 1'b0, 1'b0, 4'h5);
        send(w);
        u_host.idle_clocks();
        repeat (10) @(negedge clk_i);
        chk5(code, 5'h02);
        send(mk(5'h06, 1'b0, 1'b0, 4'h9));
        chkw(u_host.rx_q, w);
        chk4(aux, 4'h9);
    endtask
    task automatic t_long();
        u_host.send20({4'hF, mk(5'h03, 1'b0, 1'b0, 4'h6)});
        repeat (10) @(negedge clk_i);
        chk5(code, 5'h03);
        chk4(aux, 4'h6);
    endtask
    task automatic t_defer();
        send(mk(5'h05, 1'b0, 1'b1, 4'h3));
        chk5(code, 5'h03);
        chk4(aux, 4'h3);
        chk1(lpd & lzc, 1'b1, "level pending");
        send(mk(5'h07, 1'b0, 1'b1, 4'h3));
        chk5(code, 5'h03);
        pulse(1'b0);
        chk5(code, 5'h07);
        chk1(lpd, 1'b0, "level pending cleared");
        send(mk(5'h07, 1'b1, 1'b0, 4'hC));
        chk4(aux, 4'h3);
        chk1(apd & azc, 1'b1, "aux pending");
        pulse(1'b1);
        chk4(aux, 4'hC);
        chk1(apd, 1'b0, "aux pending cleared");
    endtask
    initial begin
        t_reset();
        t_codes();
        t_idle_and_chain();
        t_long();
        t_defer();
        t_reset();
        t_long();
        report_and_stop();
    end
    initial begin
        #500000;
        fail("run timed out");
        report_and_stop();
    end
endmodule // test_gain_control_serial_port
